// >>> core/liu_serial_control_port.v
// host-facing registers and line interface unit serial control port
// What this block does
// - each operation reads or writes exactly one 8-bit remote register
// - two chip select outputs for two remote units, one chosen per frame by a command bit
// - every transaction is sixteen serial clocks, command then data
// - write shifts out command register then data register
// - command register holds remote address and a read/write bit
// - read sends command byte only, captures eight bits into data
// - writing the command register starts a transaction; load data first
// - write data follows the command byte with no idle clocks
// - read data is sampled on the eight clocks after the command
// - completion sets done status; enable gates it onto shared interrupt
`timescale 1ns/10ps
`default_nettype none
`include "liu_serial_map.vh"
module liu_serial_control_port (
	input wire clock, // 100 MHz system clock
	input wire rst_n, // synchronous reset, active low
	input wire [8:0] reg_addr, // host register address
	input wire [7:0] reg_wdata, // host write data
	input wire reg_wr, // one-cycle write strobe
	input wire reg_rd, // one-cycle read strobe
	output reg [7:0] reg_rdata_ff, // read data, valid cycle after reg_rd
	input wire serial_in_pin, // serial data from remote unit
	output reg serial_out_pin, // serial data to remote unit
	output reg serial_clock_out, // generated serial clock
	output reg serial_select_first_n, // first chip select, active low
	output reg serial_select_second_n, // second chip select, active low
	output reg shared_interrupt_n, // interrupt level, low while asserted
	output reg shared_interrupt_oe_n // open-drain enable, low while driving
);
	// one-hot register selects produced by the address decoder
	localparam [3:0] SEL_COMMAND = 4'h1;
	localparam [3:0] SEL_DATA = 4'h2;
	localparam [3:0] SEL_STATUS = 4'h4;
	localparam [3:0] SEL_SETUP = 4'h8;
	// one-hot host sequencer states
	localparam [3:0] ST_IDLE = 4'h1; // no transaction pending
	localparam [3:0] ST_LAUNCH = 4'h2; // start pulse to the shifter
	localparam [3:0] ST_SHIFT = 4'h4; // frame on the link
	localparam [3:0] ST_STORE = 4'h8; // read byte just stored
	reg [7:0] serial_command_ff;
	reg [7:0] serial_data_ff;
	reg done_ff;
	reg irq_en_ff;
	reg [3:0] state_ff;
	reg [3:0] nxt_state;
	reg sdi_meta_ff;
	reg sdi_sync_ff;
	wire sck, sdo, cs1_n, cs2_n, busy, xfer_done;
	wire [7:0] rdata;
	wire irq;
	wire [3:0] sel;
	wire pending;
	wire host_wr_ok;
	wire start;
	// address decode, shared by the write, clear and read paths
	function [3:0] reg_select;
		input [8:0] addr;
		begin
			if (addr == `ADDR_SERIAL_COMMAND) begin
				reg_select = SEL_COMMAND;
			end else if (addr == `ADDR_SERIAL_DATA) begin
				reg_select = SEL_DATA;
			end else if (addr == `ADDR_SERIAL_DONE_STATUS) begin
				reg_select = SEL_STATUS;
			end else if (addr == `ADDR_SERIAL_INTERRUPT_SETUP) begin
				reg_select = SEL_SETUP;
			end else begin
				reg_select = 4'h0;
			end
		end
	endfunction
	assign sel = reg_select(reg_addr);
	// busy as the host sees it: from the command write until the read byte is stored,
	// so a poll straight after the command never reports a stale idle;
	// the shifter's own busy is kept in as a guard
	assign pending = busy | (state_ff != ST_IDLE);
	// writes that could disturb a frame are dropped while one is pending
	assign host_wr_ok = reg_wr && !pending;
	// the shifter registers this pulse, so its pins still come from flops
	assign start = (state_ff == ST_LAUNCH);
	// two-flop synchroniser on the serial input pin
	// its two cycles of latency sit well inside the four-cycle low phase of the serial clock
	always @(posedge clock) begin
		if (!rst_n) begin
			sdi_meta_ff <= 1'b0;
			sdi_sync_ff <= 1'b0;
		end else begin
			sdi_meta_ff <= serial_in_pin;
			sdi_sync_ff <= sdi_meta_ff;
		end
	end
	// host sequencer next state
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (host_wr_ok && sel == SEL_COMMAND) begin
					nxt_state = ST_LAUNCH;
				end
			end
			ST_LAUNCH: begin
				nxt_state = ST_SHIFT;
			end
			ST_SHIFT: begin
				if (xfer_done) begin
					nxt_state = ST_STORE;
				end
			end
			ST_STORE: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end
	// sequencer state register; an illegal code falls back to idle
	always @(posedge clock) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end
	// host register writes; command and data are frozen while a frame is pending,
	// which also keeps a late data write from racing the captured read byte
	always @(posedge clock) begin
		if (!rst_n) begin
			serial_command_ff <= `RESET_BYTE;
			serial_data_ff <= `RESET_BYTE;
			irq_en_ff <= 1'b0;
		end else begin
			if (xfer_done && serial_command_ff[`CMD_RW_BIT]) begin
				serial_data_ff <= rdata;
			end else if (host_wr_ok && sel == SEL_DATA) begin
				serial_data_ff <= reg_wdata;
			end
			if (host_wr_ok && sel == SEL_COMMAND) begin
				serial_command_ff <= reg_wdata;
			end
			if (host_wr_ok && sel == SEL_SETUP) begin
				irq_en_ff <= reg_wdata[`IRQ_EN_BIT];
			end
		end
	end
	// done status: set on completion, cleared by writing one; set wins a tie
	always @(posedge clock) begin
		if (!rst_n) begin
			done_ff <= 1'b0;
		end else begin
			if (xfer_done) begin
				done_ff <= 1'b1;
			end else if (reg_wr && sel == SEL_STATUS && reg_wdata[`DONE_BIT]) begin
				done_ff <= 1'b0;
			end
		end
	end
	// host register reads, registered; unmapped addresses read zero
	always @(posedge clock) begin
		if (!rst_n) begin
			reg_rdata_ff <= `RESET_BYTE;
		end else if (reg_rd) begin
			if (sel == SEL_COMMAND) begin
				reg_rdata_ff <= serial_command_ff;
			end else if (sel == SEL_DATA) begin
				reg_rdata_ff <= serial_data_ff;
			end else if (sel == SEL_STATUS) begin
				reg_rdata_ff <= {6'h00, pending, done_ff};
			end else if (sel == SEL_SETUP) begin
				reg_rdata_ff <= {7'h00, irq_en_ff};
			end else begin
				reg_rdata_ff <= `RESET_BYTE;
			end
		end
	end
	// gate onto interrupt
	// level request; it stays up until the host clears done or drops the enable
	assign irq = done_ff & irq_en_ff;
	// pin outputs retimed so each comes straight from a flop
	always @(posedge clock) begin
		if (!rst_n) begin
			serial_out_pin <= 1'b0;
			serial_clock_out <= 1'b0;
			serial_select_first_n <= 1'b1;
			serial_select_second_n <= 1'b1;
			shared_interrupt_n <= 1'b1;
			shared_interrupt_oe_n <= 1'b1;
		end else begin
			serial_out_pin <= sdo;
			serial_clock_out <= sck;
			serial_select_first_n <= cs1_n;
			serial_select_second_n <= cs2_n;
			shared_interrupt_n <= ~irq;
			shared_interrupt_oe_n <= ~irq;
		end
	end
	liu_serial_shifter u_shifter (
		.clock(clock),
		.rst_n(rst_n),
		.start(start),
		.is_read(serial_command_ff[`CMD_RW_BIT]),
		.second_sel(serial_command_ff[`CMD_SELECT_BIT]),
		.word({serial_command_ff, serial_data_ff}),
		.sdi_sync(sdi_sync_ff),
		.sck_ff(sck),
		.sdo_ff(sdo),
		.cs1_n_ff(cs1_n),
		.cs2_n_ff(cs2_n),
		.busy_ff(busy),
		.done_ff(xfer_done),
		.rdata_ff(rdata)
	);
endmodule // liu_serial_control_port
`default_nettype wire

// >>> core/liu_serial_map.vh
// register offsets, field positions, reset values and timing counts for the liu serial port
`ifndef LIU_SERIAL_MAP_VH
`define LIU_SERIAL_MAP_VH
`define ADDR_SERIAL_COMMAND 9'h022
`define ADDR_SERIAL_DATA 9'h023
`define ADDR_SERIAL_DONE_STATUS 9'h024
`define ADDR_SERIAL_INTERRUPT_SETUP 9'h025
`define CMD_RW_BIT 7
`define CMD_SELECT_BIT 6
`define DONE_BIT 0
`define IRQ_EN_BIT 0
`define RESET_BYTE 8'h00
`define FRAME_BITS 5'h10
`define CMD_BITS 5'h08
`define HALF_PERIOD_NS 40
`define CLOCK_NS 10
`define HALF_PERIOD_CYC (`HALF_PERIOD_NS / `CLOCK_NS)
`endif

// >>> core/liu_serial_shifter.v
// serial shift engine: clock divider, chip selects and 16-bit frame
`timescale 1ns/10ps
`default_nettype none
`include "liu_serial_map.vh"
module liu_serial_shifter (
	input wire clock, // system clock
	input wire rst_n, // synchronous reset, active low
	input wire start, // one-cycle start pulse
	input wire is_read, // transaction is a read
	input wire second_sel, // use second chip select
	input wire [15:0] word, // command byte then data byte
	input wire sdi_sync, // synchronised serial input
	output reg sck_ff, // serial clock out
	output reg sdo_ff, // serial data out
	output reg cs1_n_ff, // first chip select, active low
	output reg cs2_n_ff, // second chip select, active low
	output reg busy_ff, // frame in progress
	output reg done_ff, // one-cycle end of frame
	output reg [7:0] rdata_ff // captured read byte
);
	reg [15:0] shift_ff;
	reg [4:0] bit_ff;
	reg [7:0] div_ff;
	reg rd_ff;
	wire tick;
	assign tick = (div_ff == (`HALF_PERIOD_CYC - 1));
	// divider runs only inside a frame so each frame starts on a clean low phase
	always @(posedge clock) begin
		if (!rst_n) begin
			div_ff <= 8'h00;
			sck_ff <= 1'b0;
			sdo_ff <= 1'b0;
			cs1_n_ff <= 1'b1;
			cs2_n_ff <= 1'b1;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			shift_ff <= 16'h0000;
			bit_ff <= 5'h00;
			rd_ff <= 1'b0;
			rdata_ff <= `RESET_BYTE;
		end else begin
			done_ff <= 1'b0;
			if (!busy_ff) begin
				if (start) begin
					busy_ff <= 1'b1;
					shift_ff <= word;
					rd_ff <= is_read;
					bit_ff <= 5'h00;
					div_ff <= 8'h00;
					cs1_n_ff <= second_sel;
					cs2_n_ff <= ~second_sel;
					sdo_ff <= word[15];
				end
			end else if (tick) begin
				div_ff <= 8'h00;
				sck_ff <= ~sck_ff;
				if (sck_ff) begin
					// falling edge: advance to next bit
					// sixteen clocks
					if (bit_ff == (`FRAME_BITS - 5'h01)) begin
						busy_ff <= 1'b0;
						done_ff <= 1'b1;
						cs1_n_ff <= 1'b1;
						cs2_n_ff <= 1'b1;
						sdo_ff <= 1'b0;
					end else begin
						bit_ff <= bit_ff + 5'h01;
						shift_ff <= {shift_ff[14:0], 1'b0};
						sdo_ff <= (rd_ff && bit_ff >= (`CMD_BITS - 5'h01)) ? 1'b0 : shift_ff[14];
					end
				end else if (rd_ff && bit_ff >= `CMD_BITS) begin
					rdata_ff <= {rdata_ff[6:0], sdi_sync};
				end
			end else begin
				div_ff <= div_ff + 8'h01;
			end
		end
	end
endmodule // liu_serial_shifter
`default_nettype wire

// >>> bench/liu_serial_control_port_monitor.sv
// pin-level checks for the liu serial port
`timescale 1ns/10ps
`default_nettype none
module liu_serial_control_port_monitor (
	input wire logic clock, // clk
	input wire logic rst_n, // reset
	input wire logic reg_rd, // rd strobe
	input wire logic [7:0] reg_rdata_ff, // rd data
	input wire logic serial_out_pin, // sdo
	input wire logic serial_clock_out, // sck
	input wire logic serial_select_first_n, // cs1
	input wire logic serial_select_second_n, // cs2
	input wire logic shared_interrupt_n, // irq
	input wire logic shared_interrupt_oe_n // irq enable
);
	// short aliases keep the properties readable
	wire logic sck = serial_clock_out;
	wire logic idle = serial_select_first_n & serial_select_second_n;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	chk_one_select: assert property (serial_select_first_n | serial_select_second_n)
		else $error("both selects low");
	chk_frame_length: assert property ($fell(idle) |-> (!idle throughout ##127 1'b1) ##1 idle)
		else $error("frame length wrong");
	chk_sck_high: assert property ($rose(sck) |=> sck [*3] ##1 !sck)
		else $error("sck high phase");
	chk_sck_low: assert property ($fell(sck) |=> !sck [*3])
		else $error("sck low phase");
	chk_idle_clock: assert property (idle && $past(idle) |-> !sck)
		else $error("sck runs idle");
	chk_sdo_edge: assert property (!$stable(serial_out_pin) && !idle |-> !sck)
		else $error("sdo moved high");
	chk_irq_oe: assert property (shared_interrupt_oe_n == shared_interrupt_n)
		else $error("irq enable differs");
	chk_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata_ff))
		else $error("rdata moved");
endmodule // liu_serial_control_port_monitor
bind liu_serial_control_port liu_serial_control_port_monitor u_mon (.clock(clock),
	.rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
	.serial_out_pin(serial_out_pin), .serial_clock_out(serial_clock_out),
	.serial_select_first_n(serial_select_first_n),
	.serial_select_second_n(serial_select_second_n),
	.shared_interrupt_n(shared_interrupt_n), .shared_interrupt_oe_n(shared_interrupt_oe_n));
`default_nettype wire

// >>> bench/liu_partner.sv
// behavioural line interface unit on the serial link
`timescale 1ns/10ps
`default_nettype none
module liu_partner (
	input wire logic sck, // serial clock
	input wire logic sdo, // data in
	input wire logic cs1_n, // select one
	input wire logic cs2_n, // select two
	output var logic sdi // data back
);
	logic [7:0] mem [0:127];
	logic [15:0] sh;
	logic [6:0] a;
	logic rdf;
	int n = 0;
	initial sdi = 1'b0;
	// release restarts the count; stale bit is inverted
	always @(posedge cs1_n or posedge cs2_n) begin
		n = 0;
		sdi = ~sdi;
	end
	// msb first on rising sck, bank from select
	always @(posedge sck) if (!(cs1_n && cs2_n)) begin
		sh = {sh[14:0], sdo};
		n++;
		if (n == 8) a = {!cs2_n, sh[5:0]};
		if (n == 8) rdf = sh[7];
		if (n == 16 && !rdf) mem[a] = sh[7:0];
	end
	// read byte set up after each falling sck
	always @(negedge sck) if (rdf && n >= 8 && n < 16) begin
		sdi = mem[a][15-n];
	end
endmodule // liu_partner
`default_nettype wire

// >>> bench/liu_serial_control_port_bench.sv
// self-checking bench for the liu serial port
`timescale 1ns/10ps
`default_nettype none
module liu_serial_control_port_bench;
	logic clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, sdi, sdo, sck, cs1_n, cs2_n, irq_n;
	logic irq_oe_n;
	logic [8:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, reg_rdata_ff, rv;
	int miscompares = 0, cmp_count = 0;
	// command byte beside data written or expected back
	logic [15:0] rows [4] = '{16'h05A5, 16'h7F3C, 16'h85A5, 16'hFF3C};
	always #5 clock = ~clock;
	liu_serial_control_port u_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
		.serial_in_pin(sdi), .serial_out_pin(sdo), .serial_clock_out(sck),
		.serial_select_first_n(cs1_n), .serial_select_second_n(cs2_n),
		.shared_interrupt_n(irq_n), .shared_interrupt_oe_n(irq_oe_n));
	liu_partner u_liu (.sck(sck), .sdo(sdo), .cs1_n(cs1_n), .cs2_n(cs2_n), .sdi(sdi));
	task automatic check(input string s, input logic [7:0] exp, input logic [7:0] seen);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clock) #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(posedge clock) #1 reg_wr = 0;
	endtask
	task automatic rd(input logic [8:0] a);
		@(posedge clock) #1 {reg_rd, reg_addr} = {1'b1, a};
		@(posedge clock) #1 reg_rd = 0;
		rv = reg_rdata_ff;
	endtask
	// poll busy under a bound; a hang ends the run
	task automatic wait_idle;
		repeat (4) @(posedge clock);
		for (int i = 0; i < 200; i++) begin
			rd(9'h024);
			if (rv[1] === 1'b0) return;
		end
		check("busy timeout", 8'h00, 8'h01);
		report_and_stop;
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clock);
		#1 rst_n = 1;
		for (int a = 34; a < 39; a++) begin
			rd(a == 38 ? 9'h030 : a[8:0]);
			check("reset and unmapped", 8'h00, rv);
		end
		$display("reset test done");
		foreach (rows[k]) begin
			if (!rows[k][15]) wr(9'h023, rows[k][7:0]);
			wr(9'h022, rows[k][15:8]);
			wait_idle;
			if (rows[k][15]) rd(9'h023);
			else rv = u_liu.mem[rows[k][14:8]];
			check("frame byte", rows[k][7:0], rv);
		end
		$display("row tests done");
		rd(9'h024);
		check("done bit", 8'h01, rv);
		check("irq masked", 8'h01, {7'h0, irq_n});
		check("oe masked", 8'h01, {7'h0, irq_oe_n});
		wr(9'h025, 8'h01);
		repeat (3) @(posedge clock) #1;
		check("irq raised", 8'h00, {7'h0, irq_n});
		check("oe raised", 8'h00, {7'h0, irq_oe_n});
		wr(9'h024, 8'h01);
		repeat (3) @(posedge clock) #1;
		check("irq cleared", 8'h01, {7'h0, irq_n});
		check("oe cleared", 8'h01, {7'h0, irq_oe_n});
		$display("interrupt test done");
		wr(9'h023, 8'h5A);
		wr(9'h022, 8'h11);
		rd(9'h024);
		check("busy at launch", 8'h02, rv);
		repeat (3) @(posedge clock);
		wr(9'h023, 8'hFF);
		wait_idle;
		check("sent while busy", 8'h5A, u_liu.mem[7'h11]);
		rd(9'h023);
		check("data kept", 8'h5A, rv);
		$display("busy test done");
		// reset in the middle of a read frame, then a clean read
		wr(9'h022, 8'h85);
		repeat (40) @(posedge clock);
		#1 rst_n = 0;
		repeat (6) @(posedge clock);
		#1 rst_n = 1;
		check("selects after reset", 8'h03, {6'h0, cs2_n, cs1_n});
		check("sck after reset", 8'h00, {7'h0, sck});
		check("irq after reset", 8'h01, {7'h0, irq_n});
		rd(9'h024);
		check("status after reset", 8'h00, rv);
		wr(9'h022, 8'h85);
		wait_idle;
		rd(9'h023);
		check("read after reset", 8'hA5, rv);
		$display("mid-run reset test done");
		report_and_stop;
	end
endmodule // liu_serial_control_port_bench
`default_nettype wire
